//--- ssadc_pkg.sv
// Shared constants and types for the sampling converter control block
package ssadc_pkg;

  // Clock rate and times in their own units
  localparam int CLK_PERIOD_NS   = 50;
  localparam int STANDBY_WAKE_NS = 100000;
  localparam int CONV_NS         = 4000;

  // Least times round up to whole cycles
  localparam int STANDBY_WAKE_CYC = (STANDBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC         = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Converter geometry
  localparam int NUM_CH     = 8;
  localparam int RES_BITS   = 18;
  localparam int BUS_BITS   = 16;
  localparam int READ_WORDS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int TMR_W      = 13;
  localparam int OS_W       = 3;

  // Largest valid oversampling code; above it oversampling is off
  localparam logic [2:0] OS_CODE_MAX = 3'h6;

  // Bit positions in the synchronised pin vector
  localparam int PIN_W   = 11;
  localparam int PIN_G1  = 0;
  localparam int PIN_G2  = 1;
  localparam int PIN_PD  = 2;
  localparam int PIN_RNG = 3;
  localparam int PIN_CFG = 4;
  localparam int PIN_CS  = 5;
  localparam int PIN_RD  = 6;
  localparam int PIN_IF  = 7;
  localparam int PIN_OS  = 8;

  // Values after reset
  localparam logic [PIN_W-1:0]    PINS_RST   = 11'h064;
  localparam logic [3:0]          PTR_RST    = 4'h0;
  localparam logic [RES_BITS-1:0] RESULT_RST = 18'h0_0000;
  localparam logic [BUS_BITS-1:0] BUS_RST    = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,
    ST_WAKE = 3'b001,
    ST_IDLE = 3'b010,
    ST_HOLD = 3'b011,
    ST_CONV = 3'b100
  } ssadc_state_t;

endpackage : ssadc_pkg

//--- ssadc_ctrl.sv
// Conversion control, power-down handling and parallel readout of the converter
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Result FIFO between converter core and sequencer
module ssadc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,     // System clock
  input  wire logic             resetn,    // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] inData,    // Word from the core
  input  wire logic             inValid,   // Core offers a word
  output logic                  inReady,   // Room for a word
  output logic      [WIDTH-1:0] outData,   // Oldest word
  output logic                  outValid,  // A word is waiting
  input  wire logic             outReady   // Sequencer takes the word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [CW-1:0]    count_ff, nxt_count;
  logic             full_ff, nxt_full, empty_ff, nxt_empty;
  logic             doWrite, doRead;

  // Flags are registered so the ready seen outside is a clean flop
  always_comb begin
    doWrite   = inValid & ~full_ff;
    doRead    = outReady & ~empty_ff;
    nxt_wrPtr = doWrite ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
    nxt_rdPtr = doRead ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
    nxt_count = count_ff;
    if (doWrite && !doRead) begin
      nxt_count = CW'(count_ff + 1'b1);
    end else if (doRead && !doWrite) begin
      nxt_count = CW'(count_ff - 1'b1);
    end
    nxt_full  = (nxt_count == CW'(DEPTH));
    nxt_empty = (nxt_count == '0);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      full_ff  <= 1'b0;
      empty_ff <= 1'b1;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
      full_ff  <= nxt_full;
      empty_ff <= nxt_empty;
    end
  end

  // Storage has no reset; empty flag guards stale words
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  assign inReady  = ~full_ff;
  assign outValid = ~empty_ff;
  assign outData  = mem[rdPtr_ff];
endmodule : ssadc_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: sampling sequencer, power modes and parallel readout
module ssadc_ctrl #(
  parameter int NCH   = ssadc_pkg::NUM_CH,
  parameter int DEPTH = ssadc_pkg::FIFO_DEPTH
) (
  input  wire logic        clock,                   // 20 MHz system clock
  input  wire logic        resetn,                  // Synchronous reset, active low
  input  wire logic        sampleStartGroup1,       // Strobe for channels 1-4
  input  wire logic        sampleStartGroup2,       // Strobe for channels 5-8
  input  wire logic        powerDownN,              // Power-down request, active low
  input  wire logic        rangeSelect,             // Range, also picks power-down mode
  input  wire logic        configReset,             // Configuration reset pulse
  input  wire logic        interfaceSelect,         // 0 selects the parallel bus
  input  wire logic [2:0]  oversampleRatioSelect,   // Oversampling code
  input  wire logic        csN,                     // Chip select, active low
  input  wire logic        rdN,                     // Read strobe, active low
  input  wire logic [17:0] coreData,                // Core result word
  input  wire logic        coreValid,               // Core result offered
  output logic             coreReady,               // Room for a core result
  output logic             coreStart,               // Pulse: start core conversions
  output logic             busy,                    // Conversion in progress
  output logic             holdGroup1,              // Channels 1-4 in hold
  output logic             holdGroup2,              // Channels 5-8 in hold
  output logic [15:0]      parallelDataBus,         // Read data
  output logic             parallelDataOe,          // Drive enable for the data
  output logic             standbyActive,           // Standby mode
  output logic             shutdownActive,          // Shutdown mode
  output logic             rangeConfig,             // Range latched at reset pulse
  output logic             deviceReady              // Accepting strobes
);
  localparam int RB = ssadc_pkg::RES_BITS;
  localparam int TW = ssadc_pkg::TMR_W;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic [ssadc_pkg::PIN_W-1:0] pinsRaw, syncA_ff, syncB_ff, prev_ff;
  assign pinsRaw = {oversampleRatioSelect, interfaceSelect, rdN, csN, configReset,
                    rangeSelect, powerDownN, sampleStartGroup2, sampleStartGroup1};

  always_ff @(posedge clock) begin
    if (!resetn) begin
      syncA_ff <= ssadc_pkg::PINS_RST;
      syncB_ff <= ssadc_pkg::PINS_RST;
      prev_ff  <= ssadc_pkg::PINS_RST;
    end else begin
      syncA_ff <= pinsRaw;
      syncB_ff <= syncA_ff;
      prev_ff  <= syncB_ff;
    end
  end

  logic       rise1, rise2, cfgRise, rdFall, pdS, rngS, csS, rdS, ifS;
  logic [2:0] osS;
  assign pdS     = syncB_ff[ssadc_pkg::PIN_PD];
  assign rngS    = syncB_ff[ssadc_pkg::PIN_RNG];
  assign csS     = syncB_ff[ssadc_pkg::PIN_CS];
  assign rdS     = syncB_ff[ssadc_pkg::PIN_RD];
  assign ifS     = syncB_ff[ssadc_pkg::PIN_IF];
  assign osS     = syncB_ff[ssadc_pkg::PIN_OS +: ssadc_pkg::OS_W];
  assign rise1   = syncB_ff[ssadc_pkg::PIN_G1] & ~prev_ff[ssadc_pkg::PIN_G1];
  assign rise2   = syncB_ff[ssadc_pkg::PIN_G2] & ~prev_ff[ssadc_pkg::PIN_G2];
  assign cfgRise = syncB_ff[ssadc_pkg::PIN_CFG] & ~prev_ff[ssadc_pkg::PIN_CFG];
  assign rdFall  = prev_ff[ssadc_pkg::PIN_RD] & ~rdS;

  //////////////////////////////////////////////////////////////////////////////
  // Core result buffer; the sequencer drains it only while converting
  logic [RB-1:0] fifoData;
  logic          fifoValid, fifoPop, fifoReady;

  ssadc_fifo #(.WIDTH(RB), .DEPTH(DEPTH)) uFifo (
    .clock    (clock),
    .resetn   (resetn),
    .inData   (coreData),
    .inValid  (coreValid),
    .inReady  (fifoReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );
  assign coreReady = fifoReady;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  ssadc_pkg::ssadc_state_t state_ff, nxt_state;
  logic [TW-1:0] timer_ff, nxt_timer;
  logic [3:0]    collected_ff, nxt_collected;
  logic [2:0]    osLatched_ff, nxt_osLatched;
  logic [RB-1:0] shadow_ff [NCH];
  logic [RB-1:0] nxt_shadow [NCH];
  logic [RB-1:0] results_ff [NCH];
  logic [RB-1:0] nxt_results [NCH];
  logic busy_ff, nxt_busy, hold1_ff, nxt_hold1, hold2_ff, nxt_hold2;
  logic start_ff, nxt_start, needsReset_ff, nxt_needsReset;
  logic standby_ff, nxt_standby, shutdown_ff, nxt_shutdown, range_ff, nxt_range;
  logic ready_ff, nxt_ready, busyFallNow, h1, h2;

  // Next-state logic for power, sampling and conversion
  always_comb begin
    nxt_state      = state_ff;
    nxt_timer      = timer_ff;
    nxt_collected  = collected_ff;
    nxt_osLatched  = osLatched_ff;
    nxt_shadow     = shadow_ff;
    nxt_results    = results_ff;
    nxt_busy       = busy_ff;
    nxt_hold1      = hold1_ff;
    nxt_hold2      = hold2_ff;
    nxt_start      = 1'b0;
    nxt_needsReset = needsReset_ff;
    nxt_standby    = 1'b0;
    nxt_shutdown   = 1'b0;
    nxt_range      = range_ff;
    fifoPop        = 1'b0;
    busyFallNow    = 1'b0;
    h1             = hold1_ff | rise1;
    h2             = hold2_ff | rise2;
    if (cfgRise) begin
      nxt_needsReset = 1'b0;
      nxt_range      = rngS;
    end
    case (state_ff)
      ssadc_pkg::ST_OFF: begin
        if (pdS) begin
          nxt_timer = TW'(ssadc_pkg::STANDBY_WAKE_CYC - 1);
          nxt_state = ssadc_pkg::ST_WAKE;
        end
      end
      ssadc_pkg::ST_WAKE: begin
        nxt_timer = (timer_ff == '0) ? timer_ff : TW'(timer_ff - 1'b1);
        if (timer_ff == '0) begin
          nxt_state = ssadc_pkg::ST_IDLE;
        end
      end
      ssadc_pkg::ST_IDLE, ssadc_pkg::ST_HOLD: begin
        if (!needsReset_ff) begin
          if (osLatched_ff != 3'h0) begin
            h1 = rise1 | rise2;
            h2 = rise1 | rise2;
          end
          nxt_hold1 = h1;
          nxt_hold2 = h2;
          if (h1 && h2) begin
            nxt_busy      = 1'b1;
            nxt_start     = 1'b1;
            nxt_collected = 4'h0;
            nxt_timer     = TW'(TW'(ssadc_pkg::CONV_CYC) << osLatched_ff) - TW'(1);
            nxt_state     = ssadc_pkg::ST_CONV;
          end else if (h1 || h2) begin
            nxt_state = ssadc_pkg::ST_HOLD;
          end
        end
      end
      ssadc_pkg::ST_CONV: begin
        nxt_timer = (timer_ff == '0) ? timer_ff : TW'(timer_ff - 1'b1);
        if (fifoValid && collected_ff < 4'(NCH)) begin
          fifoPop       = 1'b1;
          nxt_shadow[collected_ff[2:0]] = fifoData;
          nxt_collected = 4'(collected_ff + 1'b1);
        end
        if (timer_ff == '0 && collected_ff == 4'(NCH)) begin
          nxt_busy      = 1'b0;
          nxt_hold1     = 1'b0;
          nxt_hold2     = 1'b0;
          nxt_results   = shadow_ff;
          nxt_osLatched = (osS > ssadc_pkg::OS_CODE_MAX) ? 3'h0 : osS;
          busyFallNow   = 1'b1;
          nxt_state     = ssadc_pkg::ST_IDLE;
        end
      end
      default: nxt_state = ssadc_pkg::ST_OFF;
    endcase
    if (!pdS) begin
      nxt_standby  = rngS;
      nxt_shutdown = ~rngS;
      nxt_state    = ssadc_pkg::ST_OFF;
      nxt_busy     = 1'b0;
      nxt_hold1    = 1'b0;
      nxt_hold2    = 1'b0;
      nxt_start    = 1'b0;
      busyFallNow  = 1'b0;
      // Shutdown loses configuration, so a reset pulse is needed again
      if (!rngS) begin
        nxt_needsReset = 1'b1;
      end
    end
    nxt_ready = (nxt_state == ssadc_pkg::ST_IDLE) & ~nxt_needsReset;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_ff      <= ssadc_pkg::ST_OFF;
      timer_ff      <= '0;
      collected_ff  <= 4'h0;
      osLatched_ff  <= 3'h0;
      busy_ff       <= 1'b0;
      hold1_ff      <= 1'b0;
      hold2_ff      <= 1'b0;
      start_ff      <= 1'b0;
      needsReset_ff <= 1'b1;
      standby_ff    <= 1'b0;
      shutdown_ff   <= 1'b0;
      range_ff      <= 1'b0;
      ready_ff      <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        shadow_ff[i]  <= ssadc_pkg::RESULT_RST;
        results_ff[i] <= ssadc_pkg::RESULT_RST;
      end
    end else begin
      state_ff      <= nxt_state;
      timer_ff      <= nxt_timer;
      collected_ff  <= nxt_collected;
      osLatched_ff  <= nxt_osLatched;
      busy_ff       <= nxt_busy;
      hold1_ff      <= nxt_hold1;
      hold2_ff      <= nxt_hold2;
      start_ff      <= nxt_start;
      needsReset_ff <= nxt_needsReset;
      standby_ff    <= nxt_standby;
      shutdown_ff   <= nxt_shutdown;
      range_ff      <= nxt_range;
      ready_ff      <= nxt_ready;
      shadow_ff     <= nxt_shadow;
      results_ff    <= nxt_results;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parallel readout
  logic [3:0]          ptr_ff, nxt_ptr;
  logic [15:0]         bus_ff, nxt_bus;
  logic                oe_ff, nxt_oe, readTake;
  logic [RB-1:0]       curResult;

  always_comb begin
    curResult = results_ff[ptr_ff[3:1]];
    readTake  = rdFall & ~csS & ~ifS;
    nxt_ptr   = ptr_ff;
    nxt_bus   = bus_ff;
    // drive only with both strobes low
    nxt_oe    = ~csS & ~rdS & ~ifS;
    // busy fall wins over a read
    if (busyFallNow || cfgRise) begin
      nxt_ptr = ssadc_pkg::PTR_RST;
    end else if (readTake) begin
      nxt_bus = ptr_ff[0] ? {14'h0000, curResult[1:0]} : curResult[RB-1:2];
      nxt_ptr = 4'(ptr_ff + 1'b1);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ptr_ff <= ssadc_pkg::PTR_RST;
      bus_ff <= ssadc_pkg::BUS_RST;
      oe_ff  <= 1'b0;
    end else begin
      ptr_ff <= nxt_ptr;
      bus_ff <= nxt_bus;
      oe_ff  <= nxt_oe;
    end
  end

  // Outputs straight from flops
  assign coreStart       = start_ff;
  assign busy            = busy_ff;
  assign holdGroup1      = hold1_ff;
  assign holdGroup2      = hold2_ff;
  assign parallelDataBus = bus_ff;
  assign parallelDataOe  = oe_ff;
  assign standbyActive   = standby_ff;
  assign shutdownActive  = shutdown_ff;
  assign rangeConfig     = range_ff;
  assign deviceReady     = ready_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seqBusyEnd;
    busy_ff ##1 !busy_ff;
  endsequence
  sequence seqFirstRead;
    readTake && !busyFallNow && !cfgRise;
  endsequence

  AST_POWER_MODE: assert property (!pdS |=> standby_ff == $past(rngS)
    && shutdown_ff == !$past(rngS)) else $error("power-down mode wrong");
  AST_WAKE_WAIT: assert property ((state_ff == ssadc_pkg::ST_OFF && pdS) |=>
    timer_ff == TW'(ssadc_pkg::STANDBY_WAKE_CYC - 1) ##1 !ready_ff)
    else $error("wake wait not loaded");
  AST_COMMON_START: assert property ((ready_ff && state_ff == ssadc_pkg::ST_IDLE
    && pdS && rise1 && rise2) |=> busy_ff && hold1_ff && hold2_ff && start_ff)
    else $error("common strobe did not start");
  AST_BUSY_SPAN: assert property ($rose(busy_ff) |-> busy_ff [*8])
    else $error("busy too short");
  AST_BUSY_DONE: assert property (seqBusyEnd |-> $past(collected_ff) == 4'(NCH)
    || !$past(pdS)) else $error("busy fell early");
  AST_TRACK_ON_FALL: assert property ($fell(busy_ff) |-> !hold1_ff && !hold2_ff)
    else $error("holds not released");
  AST_LATER_EDGE: assert property ((state_ff == ssadc_pkg::ST_HOLD
    && hold1_ff && !hold2_ff && !rise2 && pdS && osLatched_ff == 3'h0)
    |=> !busy_ff && hold1_ff) else $error("busy before later edge");
  AST_BUS_GATE: assert property (oe_ff |-> !$past(csS) && !$past(rdS)
    && !$past(ifS)) else $error("bus driven without strobes");
  AST_CS_RELEASE: assert property ($rose(csS) |=> !oe_ff)
    else $error("bus not released");
  AST_WORD_ORDER: assert property ((seqFirstRead ##0 (ptr_ff[0] == 1'b0)) |=>
    ptr_ff[0] && bus_ff == 16'($past(curResult) >> 2)) else $error("high word wrong");
  AST_REWIND: assert property ((busyFallNow || cfgRise) |=>
    ptr_ff == ssadc_pkg::PTR_RST) else $error("pointer not rewound");
endmodule : ssadc_ctrl

`default_nettype wire

//--- ssadc_core_model.sv
// Behavioural converter core feeding eight channel words per conversion
`timescale 1ns/1ps
`default_nettype none

module ssadc_core_model (
  input  wire logic        clock,      // System clock
  input  wire logic        resetn,     // Synchronous reset, active low
  input  wire logic        coreStart,  // Start of a conversion
  input  wire logic        coreReady,  // Room in the result FIFO
  output logic      [17:0] coreData,   // Channel result word
  output logic             coreValid   // Word on offer
);
  logic [7:0] convCnt_ff;
  logic [3:0] chan_ff;
  logic       valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // every channel pushed
  // Words go out in channel order with an idle cycle between, so the FIFO
  // sees a slow producer; a word is held until the FIFO takes it
  always_ff @(posedge clock) begin
    if (!resetn) begin
      convCnt_ff <= 8'h00;
      chan_ff    <= 4'h8;
      valid_ff   <= 1'b0;
    end else if (coreStart) begin
      convCnt_ff <= convCnt_ff + 8'h01;
      chan_ff    <= 4'h0;
    end else if (valid_ff && coreReady) begin
      valid_ff <= 1'b0;
      chan_ff  <= chan_ff + 4'h1;
    end else if (chan_ff < 4'h8) begin
      valid_ff <= 1'b1;
    end
  end

  // Word tags conversion and channel; idle data is inverted, never stale
  assign coreValid = valid_ff;
  assign coreData  = valid_ff ? {convCnt_ff, 6'h2A, chan_ff} : ~{convCnt_ff, 6'h2A, chan_ff};
endmodule : ssadc_core_model

`default_nettype wire

//--- ssadc_ctrl_tb.sv
// Self-checking testbench for the converter control and parallel readout
`timescale 1ns/1ps
`default_nettype none

module ssadc_ctrl_tb;
  logic        clock = 1'b0, resetn, sampleStartGroup1, sampleStartGroup2, powerDownN;
  logic        rangeSelect, configReset, interfaceSelect, csN, rdN, coreValid, coreReady;
  logic        coreStart, busy, holdGroup1, holdGroup2, parallelDataOe, standbyActive;
  logic        shutdownActive, rangeConfig, deviceReady;
  logic [2:0]  oversampleRatioSelect;
  logic [17:0] coreData;
  logic [15:0] parallelDataBus;
  int          err_total = 0, comparisons = 0, busyLen = 0, startCnt = 0;

  ssadc_ctrl u_ssadc_ctrl (.clock(clock), .resetn(resetn),
    .sampleStartGroup1(sampleStartGroup1), .sampleStartGroup2(sampleStartGroup2),
    .powerDownN(powerDownN), .rangeSelect(rangeSelect), .configReset(configReset),
    .interfaceSelect(interfaceSelect), .oversampleRatioSelect(oversampleRatioSelect),
    .csN(csN), .rdN(rdN), .coreData(coreData), .coreValid(coreValid),
    .coreReady(coreReady), .coreStart(coreStart), .busy(busy), .holdGroup1(holdGroup1),
    .holdGroup2(holdGroup2), .parallelDataBus(parallelDataBus),
    .parallelDataOe(parallelDataOe), .standbyActive(standbyActive),
    .shutdownActive(shutdownActive), .rangeConfig(rangeConfig), .deviceReady(deviceReady));

  ssadc_core_model u_ssadc_core_model (.clock(clock), .resetn(resetn),
    .coreStart(coreStart), .coreReady(coreReady), .coreData(coreData),
    .coreValid(coreValid));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, busy-length and start-pulse counters
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (busy === 1'b1) busyLen++;
    if (coreStart === 1'b1) startCnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and access tasks; inputs change 1 ns after the rising edge
  task automatic chkBus(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chkBus

  task automatic chkBit(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask : chkBit

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Expected bus word: even index high bits, odd index low two bits
  function automatic logic [15:0] expWord(input logic [7:0] cnv, input int idx);
    logic [17:0] r;
    r = {cnv, 6'h2A, 4'(idx / 2)};
    return (idx % 2 == 0) ? r[17:2] : {14'h0000, r[1:0]};
  endfunction : expWord

  // Strobes pass a two-flop sync, so six cycles per phase leave margin
  task automatic readWord(input logic joined, input logic [15:0] exp);
    rdN = 1'b0;
    if (joined) csN = 1'b0;
    tick(6);
    chkBit("dataOe", 1'b1, parallelDataOe);
    chkBus("dataBus", exp, parallelDataBus);
    rdN = 1'b1;
    if (joined) csN = 1'b1;
    tick(6);
    chkBit("dataOeOff", 1'b0, parallelDataOe);
  endtask : readWord

  task automatic readSeq(input logic joined, input logic [7:0] cnv, input int n);
    for (int i = 0; i < n; i++) readWord(joined, expWord(cnv, i));
  endtask : readSeq

  task automatic cfgPulse;
    int n;
    configReset = 1'b1;
    tick(6);
    configReset = 1'b0;
    n = 0;
    while (deviceReady !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chkBit("deviceReady", 1'b1, deviceReady);
  endtask : cfgPulse

  // Gap zero means one common strobe; mid reads fetch the old results; len is least busy
  task automatic convert(input int gap, input int mid, input logic [7:0] old, input int len);
    int n;
    busyLen = 0;
    startCnt = 0;
    sampleStartGroup1 = 1'b1;
    if (gap > 0) begin
      tick(gap);
      chkBit("holdFirst", 1'b1, holdGroup1);
      chkBit("holdSecond", 1'b0, holdGroup2);
      chkBit("busyEarly", 1'b0, busy);
    end
    sampleStartGroup2 = 1'b1;
    tick(6);
    chkBit("busyRise", 1'b1, busy);
    chkBit("holdAll", 1'b1, holdGroup1 & holdGroup2);
    sampleStartGroup1 = 1'b0;
    sampleStartGroup2 = 1'b0;
    readSeq(1'b1, old, mid);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    tick(2);
    chkBit("busyLen", 1'b1, busyLen >= len && busyLen <= len + 10);
    chkBit("startPulse", 1'b1, startCnt == 1);
    chkBit("holdsOff", 1'b0, holdGroup1 | holdGroup2);
  endtask : convert

  task automatic stop_test;
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about 7400 cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn, sampleStartGroup1, sampleStartGroup2, rangeSelect, configReset} = '0;
    {interfaceSelect, oversampleRatioSelect} = '0;
    {csN, rdN, powerDownN} = 3'b111;
    tick(16);
    resetn = 1'b1;
    chkBit("coreReady", 1'b1, coreReady);
    tick(2100);
    chkBit("readyBeforeCfg", 1'b0, deviceReady);
    cfgPulse();
    convert(0, 0, 8'h00, ssadc_pkg::CONV_CYC);
    csN = 1'b0;
    readSeq(1'b0, 8'h01, 16);
    csN = 1'b1;
    convert(10, 2, 8'h01, ssadc_pkg::CONV_CYC);
    readSeq(1'b1, 8'h02, 16);
    // Refused reads: deselected, then serial interface chosen
    rdN = 1'b0;
    tick(6);
    chkBit("oeDeselected", 1'b0, parallelDataOe);
    rdN = 1'b1;
    interfaceSelect = 1'b1;
    tick(1);
    csN = 1'b0;
    rdN = 1'b0;
    tick(6);
    chkBit("oeSerialSel", 1'b0, parallelDataOe);
    rdN = 1'b1;
    csN = 1'b1;
    tick(6);
    interfaceSelect = 1'b0;
    readSeq(1'b1, 8'h02, 3);
    cfgPulse();
    chkBit("rangeCfgLow", 1'b0, rangeConfig);
    readSeq(1'b1, 8'h02, 2);
    // Standby keeps configuration; shutdown needs a reset pulse after the wake
    for (int m = 1; m >= 0; m--) begin
      rangeSelect = m[0];
      powerDownN = 1'b0;
      tick(6);
      chkBit("standby", m[0], standbyActive);
      chkBit("shutdown", ~m[0], shutdownActive);
      powerDownN = 1'b1;
      rangeSelect = 1'b1;
      tick(1900);
      chkBit("readyDuringWake", 1'b0, deviceReady);
      tick(200);
      chkBit("readyAfterWake", m[0], deviceReady);
    end
    cfgPulse();
    chkBit("rangeCfgHigh", 1'b1, rangeConfig);
    // Ratio code 1, latched as a conversion ends, doubles the busy time after it; code 7 counts as off
    oversampleRatioSelect = 3'h1;
    convert(0, 0, 8'h02, ssadc_pkg::CONV_CYC);
    readSeq(1'b1, 8'h03, 2);
    oversampleRatioSelect = 3'h7;
    convert(0, 0, 8'h03, 2 * ssadc_pkg::CONV_CYC);
    readSeq(1'b1, 8'h04, 2);
    convert(0, 0, 8'h04, ssadc_pkg::CONV_CYC);
    readSeq(1'b1, 8'h05, 2);
    stop_test();
  end
endmodule : ssadc_ctrl_tb

`default_nettype wire
